// *** design/sar_adc_sequence_control.sv ***
// Sequencer, prescaler, binary search and APB register block of the converter
`timescale 1ns/10ps
module sar_adc_sequence_control
  import sar_seq_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RST_B_I,
  input wire logic [31:0] PADDR_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic COMP_I,
  input wire logic STOP_REQ_I,
  input wire logic WAIT_REQ_I,
  output analog_ctl_t ANALOG_O,
  output logic SEQ_IRQ_O
);

  logic [7:0] ctrl2;
  logic [7:0] ctrl3;
  logic [7:0] ctrl4;
  logic [7:0] ctrl5;
  logic [7:0] result_flags;
  logic seq_flag;
  logic [15:0] result [8];
  logic comp_meta;
  logic comp_sync;
  logic stop_meta;
  logic stop_sync;
  logic wait_meta;
  logic wait_sync;
  logic [4:0] pre_count;
  logic half_tick;
  logic mod_tick;
  seq_state_t state;
  logic [4:0] stage_count;
  logic [2:0] conv_index;
  logic [9:0] sar;
  logic [3:0] bit_pos;
  logic wr_access;
  logic rd_access;
  logic [3:0] word_idx;
  logic restart;
  logic halt;
  logic [4:0] smp_clks;
  logic [2:0] seq_last;
  logic [3:0] chan_sel;
  logic [15:0] justified;
  logic [9:0] final_sar;

  // Index of a register from an APB byte address
  function automatic logic [3:0] word_of(input logic [31:0] addr);
    word_of = addr[5:2]; // RULE_18
  endfunction

  // APB access decode; zero wait state slave
  assign wr_access = PSEL_I && PENABLE_I && PWRITE_I;
  assign rd_access = PSEL_I && !PENABLE_I && !PWRITE_I;
  assign word_idx = word_of(PADDR_I);
  assign restart = wr_access && (word_idx == REG_CTRL4 || word_idx == REG_CTRL5); // RULE_08
  // Abort conditions seen by the sequencer
  assign halt = !ctrl2[CTL2_PWR] || stop_sync || (wait_sync && ctrl2[CTL2_WAITPD]); // RULE_09

  // Pin inputs pass two flip-flops
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
      stop_meta <= 1'b0;
      stop_sync <= 1'b0;
      wait_meta <= 1'b0;
      wait_sync <= 1'b0;
    end else begin
      comp_meta <= COMP_I;
      comp_sync <= comp_meta;
      stop_meta <= STOP_REQ_I;
      stop_sync <= stop_meta;
      wait_meta <= WAIT_REQ_I;
      wait_sync <= wait_meta;
    end
  end

  // Control registers; power bit resets low so module starts powered down
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ctrl2 <= CTL_RST; // RULE_19
      ctrl3 <= CTL_RST;
      ctrl4 <= CTL_RST;
      ctrl5 <= CTL_RST;
    end else if (wr_access) begin
      case (word_idx)
        REG_CTRL2: ctrl2 <= PWDATA_I[7:0];
        REG_CTRL3: ctrl3 <= PWDATA_I[7:0];
        REG_CTRL4: ctrl4 <= PWDATA_I[7:0];
        REG_CTRL5: ctrl5 <= PWDATA_I[7:0];
        default: ;
      endcase
    end
  end

  // Prescaler: modulus count, then divide by two; clock enable tick keeps phase
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pre_count <= 5'h00;
      half_tick <= 1'b0;
      mod_tick <= 1'b0;
    end else if (!ctrl2[CTL2_PWR]) begin
      pre_count <= 5'h00;
      half_tick <= 1'b0;
      mod_tick <= 1'b0;
    end else if (pre_count >= ctrl4[CTL4_PRS +: 5]) begin // RULE_16
      pre_count <= 5'h00;
      half_tick <= !half_tick;
      mod_tick <= half_tick; // RULE_17
    end else begin
      pre_count <= pre_count + 5'h01;
      mod_tick <= 1'b0;
    end
  end

  // Sample time of final stage: 2, 4, 8 or 16 module clocks
  assign smp_clks = SMP_BASE_CLKS << ctrl4[CTL4_SMP +: 2]; // RULE_07
  // Last index of sequence: 1, 4 or 8 conversions
  always_comb begin
    if (ctrl3[CTL3_S8]) begin
      seq_last = 3'h7; // RULE_01
    end else if (ctrl5[CTL5_SINGLE]) begin
      seq_last = 3'h0;
    end else begin
      seq_last = 3'h3;
    end
  end

  // Channel select; special convert picks internal references
  always_comb begin
    if (state == ST_IDLE) begin
      chan_sel = SEL_NONE;
    end else if (ctrl5[CTL5_SC]) begin
      case (ctrl5[1:0]) // RULE_04
        2'h0: chan_sel = SEL_LOW_REF;
        2'h1: chan_sel = SEL_HIGH_REF;
        default: chan_sel = SEL_MID_REF;
      endcase
    end else if (ctrl5[CTL5_MULTI_CHANNEL_SELECT]) begin
      chan_sel = {1'b0, ctrl5[2:0] + conv_index}; // RULE_02 RULE_05
    end else begin
      chan_sel = {1'b0, ctrl5[2:0]}; // RULE_05
    end
  end

  // Last decision falls on the store clock, so apply it before storing
  always_comb begin
    final_sar = sar;
    if (stage_count >= 5'h02 && bit_pos != 4'hf && !comp_sync) begin
      final_sar[bit_pos] = 1'b0; // RULE_13
    end
  end

  // Justify final value: left keeps MSB at bit 15
  always_comb begin
    if (ctrl5[CTL5_RJUST]) begin
      justified = ctrl4[CTL4_RES10] ? {6'h00, final_sar} : {8'h00, final_sar[9:2]}; // RULE_15
    end else begin
      justified = ctrl4[CTL4_RES10] ? {final_sar, 6'h00} : {final_sar[9:2], 8'h00}; // RULE_15
    end
  end

  // Sequencer: three sample stages then binary search, per module clock
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state <= ST_IDLE;
      stage_count <= 5'h00;
      conv_index <= 3'h0;
      sar <= 10'h000;
      bit_pos <= 4'h0;
    end else if (halt) begin
      state <= ST_IDLE; // RULE_09 RULE_19
    end else if (restart) begin
      state <= ST_STAGE1; // RULE_20
      stage_count <= 5'h00;
      conv_index <= 3'h0;
    end else if (mod_tick) begin
      case (state)
        ST_IDLE: ;
        ST_STAGE1: begin
          if (stage_count == STAGE1_CLKS - 5'h01) begin // RULE_06
            state <= ST_STAGE2;
            stage_count <= 5'h00;
          end else begin
            stage_count <= stage_count + 5'h01;
          end
        end
        ST_STAGE2: begin
          if (stage_count == STAGE2_CLKS - 5'h01) begin // RULE_06
            state <= ST_STAGE3;
            stage_count <= 5'h00;
          end else begin
            stage_count <= stage_count + 5'h01;
          end
        end
        ST_STAGE3: begin
          if (stage_count == smp_clks - 5'h01) begin
            state <= ST_CONVERT;
            stage_count <= 5'h00;
            sar <= 10'h200;
            bit_pos <= 4'h9;
          end else begin
            stage_count <= stage_count + 5'h01;
          end
        end
        ST_CONVERT: begin
          // Two settle clocks, then one decision per bit from MSB
          stage_count <= stage_count + 5'h01;
          if (stage_count >= 5'h02 && bit_pos != 4'hf) begin // RULE_13
            if (!comp_sync) begin
              sar[bit_pos] <= 1'b0;
            end
            if (bit_pos != 4'h0) begin
              sar[bit_pos - 4'h1] <= 1'b1;
            end
            bit_pos <= bit_pos - 4'h1;
          end
          if (stage_count == (ctrl4[CTL4_RES10] ? CONV10_CLKS : CONV8_CLKS) - 5'h01) begin // RULE_14
            stage_count <= 5'h00;
            if (conv_index == seq_last) begin
              conv_index <= 3'h0;
              state <= ctrl5[CTL5_CONT] ? ST_STAGE1 : ST_IDLE; // RULE_03 RULE_21
            end else begin
              conv_index <= conv_index + 3'h1;
              state <= ST_STAGE1;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // End of a conversion, on its last module clock
  logic conv_done;
  assign conv_done = mod_tick && !halt && !restart && state == ST_CONVERT
    && stage_count == (ctrl4[CTL4_RES10] ? CONV10_CLKS : CONV8_CLKS) - 5'h01;

  // 8-bit searches stop at bit 2; the justify step drops the lower bits before storing
  logic [15:0] store_val;
  assign store_val = justified;

  // Result registers and flags; a restart clear in the same cycle wins over a set
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      for (int i = 0; i < 8; i++) begin
        result[i] <= RES_RST;
      end
      result_flags <= 8'h00;
      seq_flag <= 1'b0;
    end else begin
      if (restart) begin
        result_flags <= 8'h00; // RULE_20
        seq_flag <= 1'b0;
      end else if (conv_done) begin
        result[conv_index] <= store_val; // RULE_15 RULE_21
        result_flags[conv_index] <= 1'b1; // RULE_11
        if (conv_index == seq_last) begin
          seq_flag <= 1'b1; // RULE_10
        end
      end
    end
  end

  // Read data; a result read leaves its flag set, as a poll does
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      PRDATA_O <= 32'h00000000;
    end else if (rd_access) begin
      if (word_idx >= REG_RES0) begin
        PRDATA_O <= {16'h0000, result[word_idx[2:0]]};
      end else begin
        case (word_idx)
          REG_CTRL2: PRDATA_O <= {24'h000000, ctrl2};
          REG_CTRL3: PRDATA_O <= {24'h000000, ctrl3};
          REG_CTRL4: PRDATA_O <= {24'h000000, ctrl4};
          REG_CTRL5: PRDATA_O <= {24'h000000, ctrl5};
          REG_STAT: PRDATA_O <= {16'h0000, seq_flag, 7'h00, result_flags};
          default: PRDATA_O <= 32'h00000000;
        endcase
      end
    end
  end

  // Ready and error are fixed; unmapped words simply read zero
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O <= 1'b1;
      PSLVERR_O <= 1'b0;
    end
  end

  // Analog control outputs and interrupt, all registered
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ANALOG_O <= '0;
      SEQ_IRQ_O <= 1'b0;
    end else begin
      ANALOG_O.channel <= chan_sel;
      ANALOG_O.sample_cap <= state == ST_STAGE1; // RULE_06
      ANALOG_O.amp_drive <= state == ST_STAGE2; // RULE_06
      ANALOG_O.direct <= state == ST_STAGE3; // RULE_07
      ANALOG_O.trial <= (state == ST_CONVERT) ? sar : 10'h000; // RULE_13
      SEQ_IRQ_O <= seq_flag && ctrl2[CTL2_IE]; // RULE_12
    end
  end

endmodule // sar_adc_sequence_control

// *** include/sar_seq_pkg.sv ***
// Constants, types and field layout for the converter sequence controller
//
// Functional notes
// RULE_01 - A sequence performs one, four or eight conversions per length bits.
// RULE_02 - Multi-channel clear repeats one input; set steps across input channels.
// RULE_03 - Continuous bit restarts sequences back to back; clear runs one then idles.
// RULE_04 - Special convert makes channel select pick low, high or mid reference.
// RULE_05 - Three-bit channel field selects input; first scanned channel in multi mode.
// RULE_06 - Sample stage one lasts two module clocks, stage two four.
// RULE_07 - Final direct sample stage lasts 2, 4, 8 or 16 module clocks.
// RULE_08 - Sequences start or restart only on writes to control four or five.
// RULE_09 - Continuous runs stop on single sequence end, power-down, reset, stop, wait.
// RULE_10 - Sequence-complete flag sets when a whole sequence finishes.
// RULE_11 - Each result register has a complete flag set when it is loaded.
// RULE_12 - Optional interrupt on sequence completion; flags may be polled instead.
// RULE_13 - Binary search against trial levels held in an approximation register.
// RULE_14 - Conversion takes ten module clocks at 8 bits, twelve at 10 bits.
// RULE_15 - Result written to its register, left or right justified as configured.
// RULE_16 - Five-bit modulus prescaler divides by 1 to 32, then by two.
// RULE_17 - Module clock phase-related to peripheral clock; runs apart from bus cycles.
// RULE_18 - Registers form a block of sixteen 16-bit words.
// RULE_19 - Power-up bit resets to zero; clearing it aborts any running sequence.
// RULE_20 - Control four/five write aborts, clears flags and interrupt, starts anew.
// RULE_21 - Conversion n of a sequence goes to result register n.
package sar_seq_pkg;

  // Word offsets of the 16-word block, byte address is four times the index
  localparam logic [3:0] REG_CTRL2 = 4'h1; // power, wait, interrupt enable
  localparam logic [3:0] REG_CTRL3 = 4'h2; // eight-conversion length
  localparam logic [3:0] REG_CTRL4 = 4'h3; // resolution, sample time, prescaler
  localparam logic [3:0] REG_CTRL5 = 4'h4; // mode and channel
  localparam logic [3:0] REG_STAT = 4'h5; // flags
  localparam logic [3:0] REG_RES0 = 4'h8; // results 0..7 at 8..15

  // Control two fields
  localparam int CTL2_PWR = 7;
  localparam int CTL2_WAITPD = 6;
  localparam int CTL2_IE = 1;
  // Control three fields
  localparam int CTL3_S8 = 3;
  // Control four fields
  localparam int CTL4_RES10 = 7;
  localparam int CTL4_SMP = 5;
  localparam int CTL4_PRS = 0;
  // Control five fields
  localparam int CTL5_RJUST = 7;
  localparam int CTL5_SC = 5;
  localparam int CTL5_CONT = 4;
  localparam int CTL5_MULTI_CHANNEL_SELECT = 3;
  localparam int CTL5_SINGLE = 2;

  // Reset values
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [15:0] RES_RST = 16'h0000;

  // Stage lengths in module clocks
  localparam logic [4:0] STAGE1_CLKS = 5'h02;
  localparam logic [4:0] STAGE2_CLKS = 5'h04;
  localparam logic [4:0] CONV8_CLKS = 5'h0a;
  localparam logic [4:0] CONV10_CLKS = 5'h0c;
  localparam logic [4:0] SMP_BASE_CLKS = 5'h02;

  // Special reference and no-channel codes on the analog side
  localparam logic [3:0] SEL_LOW_REF = 4'hc;
  localparam logic [3:0] SEL_HIGH_REF = 4'hd;
  localparam logic [3:0] SEL_MID_REF = 4'he;
  localparam logic [3:0] SEL_NONE = 4'hf;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_STAGE1 = 3'b001,
    ST_STAGE2 = 3'b010,
    ST_STAGE3 = 3'b011,
    ST_CONVERT = 3'b100
  } seq_state_t;

  // Analog front-end controls
  typedef struct packed {
    logic [3:0] channel;
    logic sample_cap;
    logic amp_drive;
    logic direct;
    logic [9:0] trial;
  } analog_ctl_t;

endpackage

// *** verification/sar_adc_sequence_control_tb.sv ***
// Self-checking bench for the converter sequencer
`timescale 1ns/10ps
module sar_adc_sequence_control_tb;
  import sar_seq_pkg::*;
  logic CLOCK_I, RST_B_I, PSEL_I, PENABLE_I, PWRITE_I, COMP_I, STOP_REQ_I, WAIT_REQ_I;
  logic [31:0] PADDR_I, PWDATA_I, PRDATA_O, rd;
  logic PREADY_O, PSLVERR_O, SEQ_IRQ_O;
  analog_ctl_t ANALOG_O;
  int errors = 0;
  int comparisons = 0;
  // Rows: control three, control four, control five, conversions
  logic [31:0] tab [7] = '{32'h00818701, 32'h00210a04, 32'h08418b08, 32'h009f8501,
    32'h00e1a004, 32'h00e1a104, 32'h00812601};
  sar_adc_sequence_control dut (.CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I), .PADDR_I(PADDR_I),
    .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PWDATA_I(PWDATA_I),
    .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .COMP_I(COMP_I),
    .STOP_REQ_I(STOP_REQ_I), .WAIT_REQ_I(WAIT_REQ_I), .ANALOG_O(ANALOG_O),
    .SEQ_IRQ_O(SEQ_IRQ_O));
  sar_front_end_model fe (.clock_i(CLOCK_I), .analog_i(ANALOG_O), .comp_o(COMP_I));
  initial begin
    CLOCK_I = 1'b0;
    forever #5 CLOCK_I = ~CLOCK_I;
  end
  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One transfer; request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [3:0] wi, input logic [7:0] d);
    int i;
    {PSEL_I, PWRITE_I, PADDR_I, PWDATA_I} <= {1'b1, w, 26'h0, wi, 2'b00, 24'h0, d};
    @(posedge CLOCK_I);
    PENABLE_I <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge CLOCK_I);
      if (PREADY_O === 1'b1) break;
    end
    rd = PRDATA_O;
    {PSEL_I, PENABLE_I} <= 2'b00;
    if (i == 20) begin
      errors++;
      end_of_test();
    end
    @(posedge CLOCK_I);
  endtask
  // Polls the status word; a lost sequence ends the run
  task automatic wait_done();
    int i;
    for (i = 0; i < 3000 && rd[15] !== 1'b1; i++) apb(1'b0, REG_STAT, 8'h00);
    if (i == 3000) begin
      errors++;
      end_of_test();
    end
  endtask
  task automatic quiet(input int n);
    int hits = 0;
    repeat (n) begin
      @(negedge CLOCK_I);
      if (ANALOG_O.sample_cap !== 1'b0) hits++;
    end
    chk("idle sampling", 0, hits);
  endtask
  task automatic regs_reset();
    for (int k = 1; k < 16; k++) begin
      apb(1'b0, 4'(k), 8'h00);
      chk("reset value", 0, rd);
    end
    apb(1'b1, 4'h6, 8'h5a);
    apb(1'b0, 4'h6, 8'h00);
    chk("unmapped word", 0, rd);
    $display("register reset test done");
  endtask
  task automatic run(input logic [31:0] row);
    logic [9:0] v;
    logic [3:0] ch;
    logic [7:0] c4 = row[23:16];
    logic [7:0] c5 = row[15:8];
    apb(1'b1, REG_CTRL3, row[31:24]);
    apb(1'b1, REG_CTRL4, c4);
    apb(1'b1, REG_CTRL5, c5);
    rd = 32'h0;
    wait_done();
    chk("irq", 32'h1, {31'h0, SEQ_IRQ_O});
    for (int k = 0; k < int'(row[7:0]); k++) begin
      ch = {1'b0, c5[2:0] + (c5[CTL5_MULTI_CHANNEL_SELECT] ? 3'(k) : 3'h0)};
      if (c5[CTL5_SC]) ch = (ch == 4'h0) ? SEL_LOW_REF : (ch == 4'h1) ? SEL_HIGH_REF : SEL_MID_REF;
      v = fe.level(ch);
      if (!c4[CTL4_RES10]) v = {2'b00, v[9:2]};
      apb(1'b0, REG_RES0 + 4'(k), 8'h00);
      chk("result", c5[CTL5_RJUST] ? 32'(v) : 32'(16'(v) << (c4[CTL4_RES10] ? 6 : 8)), rd);
    end
    apb(1'b0, REG_STAT, 8'h00);
    chk("status", 32'h8000 | ((32'h1 << row[7:0]) - 32'h1), rd & 32'h80ff);
    $display("sequence %h done", row);
  endtask
  task automatic cont_stop();
    int i;
    apb(1'b1, REG_CTRL5, 8'h94);
    apb(1'b0, REG_STAT, 8'h00);
    chk("flags after restart", 0, rd & 32'h80ff);
    wait_done();
    for (i = 0; i < 400 && ANALOG_O.sample_cap !== 1'b1; i++) @(posedge CLOCK_I);
    chk("continuous restart", 1, i < 400);
    STOP_REQ_I <= 1'b1;
    repeat (8) @(posedge CLOCK_I);
    chk("stop channel", SEL_NONE, ANALOG_O.channel);
    STOP_REQ_I <= 1'b0;
    quiet(300);
    apb(1'b1, REG_CTRL2, 8'hc2);
    apb(1'b1, REG_CTRL5, 8'h94);
    WAIT_REQ_I <= 1'b1;
    repeat (8) @(posedge CLOCK_I);
    chk("wait channel", SEL_NONE, ANALOG_O.channel);
    WAIT_REQ_I <= 1'b0;
    quiet(300);
    apb(1'b1, REG_CTRL3, 8'h00);
    quiet(300);
    apb(1'b1, REG_CTRL5, 8'h84);
    apb(1'b1, REG_CTRL2, 8'h02);
    @(posedge CLOCK_I);
    quiet(2000);
    apb(1'b0, REG_STAT, 8'h00);
    chk("aborted flag", 0, rd & 32'h8000);
    $display("continuous and abort test done");
  endtask
  initial begin
    {RST_B_I, PSEL_I, PENABLE_I, PWRITE_I, STOP_REQ_I, WAIT_REQ_I} = 6'h00;
    {PADDR_I, PWDATA_I} = 64'h0;
    repeat (4) @(posedge CLOCK_I);
    RST_B_I <= 1'b1;
    @(posedge CLOCK_I);
    regs_reset();
    apb(1'b1, REG_CTRL2, 8'h82);
    for (int k = 0; k < 7; k++) run(tab[k]);
    cont_stop();
    end_of_test();
  end
endmodule // sar_adc_sequence_control_tb

// *** verification/sar_front_end_model.sv ***
// Behavioural sample-and-hold and comparator facing the sequencer
`timescale 1ns/10ps
module sar_front_end_model
  import sar_seq_pkg::*;
(
  input wire logic clock_i,
  input wire analog_ctl_t analog_i,
  output logic comp_o
);
  logic [9:0] held = 10'h155;
  logic wander = 1'b0;
  // Input levels; references sit at the ends and the middle
  function automatic logic [9:0] level(input logic [3:0] ch);
    case (ch)
      SEL_LOW_REF: level = 10'h000;
      SEL_HIGH_REF: level = 10'h3ff;
      SEL_MID_REF: level = 10'h200;
      default: level = 10'h05a + 10'(ch[2:0]) * 10'h071;
    endcase
  endfunction
  // Storage node follows the input only while directly connected
  always @(posedge clock_i) begin
    if (analog_i.direct) held <= level(analog_i.channel);
    wander <= ~wander;
  end
  // Released comparator wanders, so a stale decision cannot pass
  assign comp_o = (analog_i.channel == SEL_NONE) ? wander : (held >= analog_i.trial);
endmodule // sar_front_end_model

// *** verification/sar_seq_checker.sv ***
// Port-level assertions for the converter sequencer
`timescale 1ns/10ps
module sar_seq_checker
  import sar_seq_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RST_B_I,
  input wire logic [31:0] PADDR_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic STOP_REQ_I,
  input wire logic WAIT_REQ_I,
  input wire analog_ctl_t ANALOG_O,
  input wire logic SEQ_IRQ_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RST_B_I);
  wire wr = PSEL_I && PENABLE_I && PWRITE_I;
  wire [3:0] wi = PADDR_I[5:2];
  logic [4:0] prs;
  logic [1:0] smp;
  logic spec, ie;
  logic [11:0] n1, n2, n3, clean;
  wire [11:0] tk = {6'h00, prs, 1'b0} + 12'h002;
  // Shadow fields; stage runs and quiet time since any disturbance
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      {prs, smp, spec, ie} <= '0;
      {n1, n2, n3, clean} <= '0;
    end else begin
      if (wr && wi == REG_CTRL4) {smp, prs} <= {PWDATA_I[6:5], PWDATA_I[4:0]};
      if (wr && wi == REG_CTRL5) spec <= PWDATA_I[CTL5_SC];
      if (wr && wi == REG_CTRL2) ie <= PWDATA_I[CTL2_IE];
      n1 <= ANALOG_O.sample_cap ? n1 + 12'h001 : 12'h000;
      n2 <= ANALOG_O.amp_drive ? n2 + 12'h001 : 12'h000;
      n3 <= ANALOG_O.direct ? n3 + 12'h001 : 12'h000;
      // Any write may abort a stage, so lengths are judged only after quiet time
      clean <= (wr || STOP_REQ_I || WAIT_REQ_I) ? 12'h000 : clean + {11'h000, ~&clean};
    end
  end
  property p_stage1;
    $fell(ANALOG_O.sample_cap) && clean > n1 + 12'h004 |-> n1 == 2 * tk && ANALOG_O.amp_drive;
  endproperty
  a_stage1: assert property (p_stage1) else $error("capture stage length wrong");
  property p_stage2;
    $fell(ANALOG_O.amp_drive) && clean > n2 + 12'h004 |-> n2 == 4 * tk && ANALOG_O.direct;
  endproperty
  a_stage2: assert property (p_stage2) else $error("buffer stage length wrong");
  property p_stage3;
    $fell(ANALOG_O.direct) && clean > n3 + 12'h004 |-> n3 == tk * (12'h002 << smp);
  endproperty
  a_stage3: assert property (p_stage3) else $error("direct stage length wrong");
  property p_refsel;
    ANALOG_O.sample_cap && spec && clean > 12'h004 |-> ANALOG_O.channel inside {[4'hc:4'he]};
  endproperty
  a_refsel: assert property (p_refsel) else $error("reference not selected");
  property p_extsel;
    ANALOG_O.sample_cap && !spec && clean > 12'h004 |-> !ANALOG_O.channel[3];
  endproperty
  a_extsel: assert property (p_extsel) else $error("external input not selected");
  property p_restart;
    wr && (wi == REG_CTRL4 || wi == REG_CTRL5) |-> ##2 !SEQ_IRQ_O;
  endproperty
  a_restart: assert property (p_restart) else $error("interrupt kept over restart");
  property p_irqen;
    !ie |-> ##1 !SEQ_IRQ_O;
  endproperty
  a_irqen: assert property (p_irqen) else $error("interrupt while disabled");
  property p_stop;
    $rose(STOP_REQ_I) |-> ##[1:6] ANALOG_O.channel == SEL_NONE;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not halt");
  property p_pwr;
    wr && wi == REG_CTRL2 && !PWDATA_I[CTL2_PWR] |-> ##[1:4] ANALOG_O.channel == SEL_NONE;
  endproperty
  a_pwr: assert property (p_pwr) else $error("power-down did not abort");
  property p_ready;
    $past(RST_B_I) |-> PREADY_O && !PSLVERR_O;
  endproperty
  a_ready: assert property (p_ready) else $error("bus answer wrong");
endmodule // sar_seq_checker

bind sar_adc_sequence_control sar_seq_checker chk (.CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I),
  .PADDR_I(PADDR_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
  .PWDATA_I(PWDATA_I), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .STOP_REQ_I(STOP_REQ_I), .WAIT_REQ_I(WAIT_REQ_I), .ANALOG_O(ANALOG_O),
  .SEQ_IRQ_O(SEQ_IRQ_O));
